// ### logic/igp_regs.svh
// constants of the image geometry pipeline: sizes, codes, reset values
// assumes inclusion by bare name from the package and the design files
`ifndef IGP_REGS_SVH
`define IGP_REGS_SVH

// sensor geometry and field widths
`define IGP_SENSOR_COLS 12'h990
`define IGP_SENSOR_ROWS 12'h800
`define IGP_COORD_W 12
`define IGP_PIX_W 16
`define IGP_FACT_W 3
`define IGP_STRIDE_W 6
`define IGP_LAY_W 4
`define IGP_FILT_W 3
`define IGP_BPP_W 6
`define IGP_ACC_W 24

// factor values
`define IGP_FACT_ONE 3'h1
`define IGP_STRIDE_ONE 6'h01

// output pixel layouts
`define IGP_LAY_MONO8 4'h0
`define IGP_LAY_MONO16 4'h1
`define IGP_LAY_RG8 4'h2
`define IGP_LAY_BG8 4'h5
`define IGP_LAY_RG16 4'h6
`define IGP_LAY_BG16 4'h9
`define IGP_LAY_RGB8 4'hA
`define IGP_LAY_MONO12P 4'hB

// colour filter codes
`define IGP_FILT_NONE 3'h0
`define IGP_FILT_RG 3'h1

// bits per output pixel and per colour component
`define IGP_BPP_8 6'h08
`define IGP_BPP_12 6'h0C
`define IGP_BPP_16 6'h10
`define IGP_BPP_24 6'h18

// saturation value of a combined pixel, and the zero pixel value
`define IGP_PIX_FULL 16'hFFFF
`define IGP_PIX_ZERO 16'h0000

`endif

// ### logic/igp_pkg.sv
// types shared by the image geometry pipeline files
// assumes igp_regs.svh is on the include path
`include "igp_regs.svh"

package igp_pkg;

  // one pixel on a stream with its framing flags
  typedef struct packed {
    logic [`IGP_PIX_W-1:0] data;
    logic sof;
    logic eol;
    logic eof;
  } igp_pix_t;

  // horizontal and vertical factor pair of one engine or layer
  typedef struct packed {
    logic [`IGP_FACT_W-1:0] h;
    logic [`IGP_FACT_W-1:0] v;
  } igp_fact_t;

  typedef enum logic [2:0] {
    IGP_S_IDLE = 3'h1,
    IGP_S_LOAD = 3'h2,
    IGP_S_READ = 3'h4
  } igp_state_t;

endpackage : igp_pkg

// ### logic/igp_skid.sv
// two-entry pixel buffer with valid and ready on both sides
// assumes one clock, synchronous active-high reset
`include "igp_regs.svh"

module igp_skid (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  input wire igp_pkg::igp_pix_t in_pix,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output igp_pkg::igp_pix_t out_pix,
  input wire logic out_ready
);
  import igp_pkg::*;

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  igp_pix_t tail_r;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= 2'h0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != 2'h2);
      out_valid <= (cnt_nxt != 2'h0);
    end
  end

  // data moves without reset; valid flags guard it
  always_ff @(posedge mclk) begin
    if (pop) begin
      if (cnt_r == 2'h2) begin
        out_pix <= tail_r;
      end else if (push) begin
        out_pix <= in_pix;
      end
    end else if (push) begin
      if (cnt_r == 2'h0) begin
        out_pix <= in_pix;
      end else begin
        tail_r <= in_pix;
      end
    end
  end

endmodule : igp_skid

// ### logic/igp_top.sv
// image geometry stage: mirror, crop, bin or decimate, report geometry
// assumes all inputs come from logic on mclk; one frame held in memory
//
// Contract
// - horizontal mirror reverses column order per row
// - vertical mirror outputs last row first
// - crop offsets apply in mirrored coordinates
// - horizontal mirror swaps mosaic column phase
// - vertical mirror swaps mosaic row phase
// - max width after binning or decimation, ignores crop
// - max height after binning or decimation, ignores crop
// - column factor combines adjacent columns; 1 none
// - row factor combines adjacent rows; 1 none
// - decimation acts only with binning factor 1
// - decimation only discards unkept pixels
// - dynamic range minimum reports darkest value
// - dynamic range maximum reports brightest value
// - filter reported only for mosaic layouts
// - core enable decides processing core use
// - selector picks binning engine for factors
// - selector picks decimation layer for factors
// - sensor width and height read-only
// - offsets in pixels; output equals crop size clipped to the reduced image
// - report bits per output pixel
// - decimation keeps one pixel per window
// - binning acts only with decimation factor 1
`include "igp_regs.svh"

module igp_top #(
  parameter int COLS = `IGP_SENSOR_COLS,
  parameter int ROWS = `IGP_SENSOR_ROWS,
  parameter bit COLOUR_SENSOR = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // sensor pixel stream in
  input wire logic in_valid,
  input wire igp_pkg::igp_pix_t in_pix,
  output logic in_ready,
  // processed pixel stream out
  output logic out_valid,
  output igp_pkg::igp_pix_t out_pix,
  input wire logic out_ready,
  // geometry settings
  input wire logic mirror_columns,
  input wire logic mirror_rows,
  input wire logic [`IGP_COORD_W-1:0] crop_column_offset,
  input wire logic [`IGP_COORD_W-1:0] crop_row_offset,
  input wire logic [`IGP_COORD_W-1:0] crop_width,
  input wire logic [`IGP_COORD_W-1:0] crop_height,
  input wire logic [`IGP_LAY_W-1:0] output_pixel_layout,
  input wire logic proc_core_enable,
  // binning engine and decimation layer loading
  input wire logic combine_engine_sel,
  input wire logic [`IGP_FACT_W-1:0] column_combine_factor,
  input wire logic [`IGP_FACT_W-1:0] row_combine_factor,
  input wire logic combine_load,
  input wire logic skip_layer_sel,
  input wire logic [`IGP_FACT_W-1:0] column_skip_factor,
  input wire logic [`IGP_FACT_W-1:0] row_skip_factor,
  input wire logic skip_load,
  // status
  output logic [`IGP_COORD_W-1:0] sensor_column_count,
  output logic [`IGP_COORD_W-1:0] sensor_row_count,
  output logic [`IGP_COORD_W-1:0] max_image_width,
  output logic [`IGP_COORD_W-1:0] max_image_height,
  output logic [`IGP_LAY_W-1:0] reported_pixel_layout,
  output logic [`IGP_FILT_W-1:0] colour_filter,
  output logic [`IGP_BPP_W-1:0] bits_per_output_pixel,
  output logic [`IGP_PIX_W-1:0] dyn_range_min,
  output logic [`IGP_PIX_W-1:0] dyn_range_max
);
  import igp_pkg::*;

  localparam int CW = `IGP_COORD_W;
  localparam int SW = `IGP_STRIDE_W;
  localparam int PW = `IGP_PIX_W;
  localparam int AW = $clog2(COLS * ROWS);
  localparam logic [AW-1:0] LAST_ADDR = AW'(COLS * ROWS - 1);
  localparam logic [CW-1:0] COLS_C = CW'(COLS);
  localparam logic [CW-1:0] ROWS_C = CW'(ROWS);

  // -------------------------------------------------------------
  // factor storage
  // -------------------------------------------------------------
  igp_fact_t eng_r [2];
  igp_fact_t lay_r [2];

  function automatic logic [`IGP_FACT_W-1:0] igp_fix(
      input logic [`IGP_FACT_W-1:0] f);
    igp_fix = (f == '0) ? `IGP_FACT_ONE : f;
  endfunction : igp_fix

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        eng_r[i] <= '{h: `IGP_FACT_ONE, v: `IGP_FACT_ONE};
        lay_r[i] <= '{h: `IGP_FACT_ONE, v: `IGP_FACT_ONE};
      end
    end else begin
      if (combine_load) begin
        eng_r[combine_engine_sel] <= '{h: igp_fix(column_combine_factor),
            v: igp_fix(row_combine_factor)};
      end
      if (skip_load) begin
        lay_r[skip_layer_sel] <= '{h: igp_fix(column_skip_factor),
            v: igp_fix(row_skip_factor)};
      end
    end
  end

  // -------------------------------------------------------------
  // effective factors and strides
  // -------------------------------------------------------------
  logic [`IGP_FACT_W-1:0] core_h;
  logic [`IGP_FACT_W-1:0] core_v;
  logic [SW-1:0] comb_h;
  logic [SW-1:0] comb_v;
  logic [SW-1:0] skip_h;
  logic [SW-1:0] skip_v;
  logic [SW-1:0] eff_comb_h;
  logic [SW-1:0] eff_comb_v;
  logic [SW-1:0] stride_h;
  logic [SW-1:0] stride_v;

  // second engine sits in the processing core
  assign core_h = proc_core_enable ? eng_r[1].h : `IGP_FACT_ONE;
  assign core_v = proc_core_enable ? eng_r[1].v : `IGP_FACT_ONE;
  assign comb_h = SW'(eng_r[0].h * core_h);
  assign comb_v = SW'(eng_r[0].v * core_v);
  assign skip_h = SW'(lay_r[0].h * lay_r[1].h);
  assign skip_v = SW'(lay_r[0].v * lay_r[1].v);
  assign eff_comb_h = (skip_h == `IGP_STRIDE_ONE) ? comb_h
                                                  : `IGP_STRIDE_ONE;
  assign eff_comb_v = (skip_v == `IGP_STRIDE_ONE) ? comb_v
                                                  : `IGP_STRIDE_ONE;
  // skipping counts only while binning is off; kept pixel is window start
  assign stride_h = (comb_h == `IGP_STRIDE_ONE) ? skip_h : eff_comb_h;
  assign stride_v = (comb_v == `IGP_STRIDE_ONE) ? skip_v : eff_comb_v;

  // -------------------------------------------------------------
  // geometry and format reporting
  // -------------------------------------------------------------
  logic [CW-1:0] max_w;
  logic [CW-1:0] max_h;
  logic [CW-1:0] w_eff;
  logic [CW-1:0] h_eff;
  logic is_mosaic;
  logic is_16;
  logic [1:0] phase;
  logic [1:0] flip_phase;
  logic [`IGP_LAY_W-1:0] lay_rep;
  logic [`IGP_BPP_W-1:0] bpp;
  logic [`IGP_BPP_W-1:0] comp_bits;
  logic [PW-1:0] range_max;

  assign max_w = COLS_C / {{(CW-SW){1'b0}}, stride_h};
  assign max_h = ROWS_C / {{(CW-SW){1'b0}}, stride_v};
  // crop clipped to what fits in the reduced image
  assign w_eff = (crop_column_offset >= max_w) ? '0 :
      ((crop_width < max_w - crop_column_offset) ? crop_width
                                : max_w - crop_column_offset);
  assign h_eff = (crop_row_offset >= max_h) ? '0 :
      ((crop_height < max_h - crop_row_offset) ? crop_height
                                : max_h - crop_row_offset);

  assign is_mosaic = (output_pixel_layout >= `IGP_LAY_RG8) &&
                     (output_pixel_layout <= `IGP_LAY_BG16);
  assign is_16 = (output_pixel_layout >= `IGP_LAY_RG16);
  assign phase = is_16 ? 2'(output_pixel_layout - `IGP_LAY_RG16)
                       : 2'(output_pixel_layout - `IGP_LAY_RG8);
  // bit 0 is column phase, bit 1 row phase of the mosaic
  assign flip_phase = phase ^ {mirror_rows, mirror_columns};
  assign lay_rep = (is_mosaic && COLOUR_SENSOR) ?
      ((is_16 ? `IGP_LAY_RG16 : `IGP_LAY_RG8) + {2'h0, flip_phase})
      : output_pixel_layout;

  function automatic logic [`IGP_BPP_W-1:0] igp_bpp(
      input logic [`IGP_LAY_W-1:0] lay);
    if (lay == `IGP_LAY_MONO16 || (lay >= `IGP_LAY_RG16 &&
        lay <= `IGP_LAY_BG16)) begin
      igp_bpp = `IGP_BPP_16;
    end else if (lay == `IGP_LAY_RGB8) begin
      igp_bpp = `IGP_BPP_24;
    end else if (lay == `IGP_LAY_MONO12P) begin
      igp_bpp = `IGP_BPP_12;
    end else begin
      igp_bpp = `IGP_BPP_8;
    end
  endfunction : igp_bpp

  assign bpp = igp_bpp(output_pixel_layout);
  // per colour component on three-channel layouts
  assign comp_bits = (output_pixel_layout == `IGP_LAY_RGB8) ? `IGP_BPP_8
                                                            : bpp;
  assign range_max = PW'((17'h00001 << comp_bits) - 17'h00001);

  always_ff @(posedge mclk) begin
    if (rst) begin
      sensor_column_count <= '0;
      sensor_row_count <= '0;
      max_image_width <= '0;
      max_image_height <= '0;
      reported_pixel_layout <= `IGP_LAY_MONO8;
      colour_filter <= `IGP_FILT_NONE;
      bits_per_output_pixel <= `IGP_BPP_8;
      dyn_range_min <= `IGP_PIX_ZERO;
      dyn_range_max <= `IGP_PIX_ZERO;
    end else begin
      sensor_column_count <= COLS_C;
      sensor_row_count <= ROWS_C;
      max_image_width <= max_w;
      max_image_height <= max_h;
      reported_pixel_layout <= lay_rep;
      colour_filter <= (is_mosaic && COLOUR_SENSOR) ?
          `IGP_FILT_RG + {1'b0, flip_phase} : `IGP_FILT_NONE;
      bits_per_output_pixel <= bpp;
      dyn_range_min <= `IGP_PIX_ZERO;
      dyn_range_max <= range_max;
    end
  end

  // -------------------------------------------------------------
  // frame store and sequencer
  // -------------------------------------------------------------
  logic [PW-1:0] mem [COLS * ROWS];
  igp_state_t state_r;
  igp_state_t state_nxt;
  logic [AW-1:0] wr_r;
  logic [CW-1:0] col_r;
  logic [CW-1:0] row_r;
  logic [SW-1:0] kx_r;
  logic [SW-1:0] ky_r;
  logic [`IGP_ACC_W-1:0] acc_r;
  // settings frozen for the frame being read
  logic mh_r;
  logic mv_r;
  logic [CW-1:0] offc_r;
  logic [CW-1:0] offr_r;
  logic [CW-1:0] w_r;
  logic [CW-1:0] h_r;
  logic [SW-1:0] sh_r;
  logic [SW-1:0] sv_r;
  logic [SW-1:0] ch_r;
  logic [SW-1:0] cv_r;

  logic wr_en;
  logic load_done;
  logic last_kx;
  logic last_k;
  logic last_col;
  logic last_row;
  logic buf_ready;
  logic step;
  logic [CW+SW-1:0] fx_w;
  logic [CW+SW-1:0] fy_w;
  logic [CW-1:0] fx;
  logic [CW-1:0] fy;
  logic [CW-1:0] px;
  logic [CW-1:0] py;
  logic [AW-1:0] rd_addr;
  logic [`IGP_ACC_W-1:0] acc_nxt;
  igp_pix_t push_pix;

  assign wr_en = in_valid && in_ready &&
      ((state_r == IGP_S_LOAD) || (state_r == IGP_S_IDLE && in_pix.sof));
  assign load_done = (state_r == IGP_S_LOAD) && wr_en && wr_r == LAST_ADDR;

  // source coordinate: cropped, reduced, then mirrored
  assign fx_w = (CW+SW)'(offc_r + col_r) * (CW+SW)'(sh_r)
              + (CW+SW)'(kx_r);
  assign fy_w = (CW+SW)'(offr_r + row_r) * (CW+SW)'(sv_r)
              + (CW+SW)'(ky_r);
  assign fx = CW'(fx_w);
  assign fy = CW'(fy_w);
  assign px = mh_r ? COLS_C - CW'(1) - fx : fx;
  assign py = mv_r ? ROWS_C - CW'(1) - fy : fy;
  assign rd_addr = AW'(py * COLS_C) + AW'(px);

  assign last_kx = (kx_r == ch_r - SW'(1));
  assign last_k = last_kx && (ky_r == cv_r - SW'(1));
  assign last_col = (col_r == w_r - CW'(1));
  assign last_row = (row_r == h_r - CW'(1));
  assign step = (state_r == IGP_S_READ) && (buf_ready || !last_k);
  assign acc_nxt = ((kx_r == '0 && ky_r == '0) ? '0 : acc_r)
                 + `IGP_ACC_W'(mem[rd_addr]);
  assign push_pix.data = (acc_nxt > `IGP_ACC_W'(`IGP_PIX_FULL)) ?
      `IGP_PIX_FULL : PW'(acc_nxt);
  assign push_pix.sof = (col_r == '0) && (row_r == '0);
  assign push_pix.eol = last_col;
  assign push_pix.eof = last_col && last_row;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      IGP_S_IDLE: begin
        if (wr_en) begin
          state_nxt = IGP_S_LOAD;
        end
      end
      IGP_S_LOAD: begin
        if (load_done) begin
          state_nxt = (w_eff == '0 || h_eff == '0) ? IGP_S_IDLE
                                                   : IGP_S_READ;
        end
      end
      IGP_S_READ: begin
        if (step && last_k && last_col && last_row) begin
          state_nxt = IGP_S_IDLE;
        end
      end
      default: state_nxt = IGP_S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_r] <= in_pix.data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= IGP_S_IDLE;
      in_ready <= 1'b0;
      wr_r <= '0;
    end else begin
      state_r <= state_nxt;
      in_ready <= (state_nxt != IGP_S_READ);
      wr_r <= load_done ? '0 : (wr_en ? wr_r + AW'(1) : wr_r);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      {mh_r, mv_r} <= 2'h0;
      {offc_r, offr_r, w_r, h_r} <= '0;
      {sh_r, sv_r} <= {`IGP_STRIDE_ONE, `IGP_STRIDE_ONE};
      {ch_r, cv_r} <= {`IGP_STRIDE_ONE, `IGP_STRIDE_ONE};
    end else if (load_done) begin
      {mh_r, mv_r} <= {mirror_columns, mirror_rows};
      {offc_r, offr_r} <= {crop_column_offset, crop_row_offset};
      {w_r, h_r} <= {w_eff, h_eff};
      {sh_r, sv_r} <= {stride_h, stride_v};
      {ch_r, cv_r} <= {eff_comb_h, eff_comb_v};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || load_done) begin
      {col_r, row_r} <= '0;
      {kx_r, ky_r} <= '0;
      acc_r <= '0;
    end else if (step) begin
      acc_r <= acc_nxt;
      kx_r <= last_kx ? '0 : kx_r + SW'(1);
      ky_r <= last_k ? '0 : (last_kx ? ky_r + SW'(1) : ky_r);
      col_r <= (last_k && last_col) ? '0 : (last_k ? col_r + CW'(1) : col_r);
      row_r <= (last_k && last_col) ? row_r + CW'(1) : row_r;
    end
  end

  // -------------------------------------------------------------
  // output buffer
  // -------------------------------------------------------------
  igp_skid u_skid (
    .mclk(mclk),
    .rst(rst),
    .in_valid((state_r == IGP_S_READ) && last_k),
    .in_pix(push_pix),
    .in_ready(buf_ready),
    .out_valid(out_valid),
    .out_pix(out_pix),
    .out_ready(out_ready)
  );

endmodule : igp_top

// ### test/igp_top_chk.sv
// checker for igp_top status outputs and output handshake
// assumes binding into igp_top, one clock mclk, sync reset rst
`include "igp_regs.svh"

module igp_top_chk #(
  parameter int COLS = 4,
  parameter int ROWS = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // output stream
  input wire logic out_valid,
  input wire logic out_ready,
  input wire igp_pkg::igp_pix_t out_pix,
  // settings
  input wire logic mirror_columns,
  input wire logic mirror_rows,
  input wire logic [`IGP_LAY_W-1:0] output_pixel_layout,
  // status
  input wire logic [`IGP_COORD_W-1:0] sensor_column_count,
  input wire logic [`IGP_COORD_W-1:0] sensor_row_count,
  input wire logic [`IGP_LAY_W-1:0] reported_pixel_layout,
  input wire logic [`IGP_FILT_W-1:0] colour_filter,
  input wire logic [`IGP_BPP_W-1:0] bits_per_output_pixel,
  input wire logic [`IGP_PIX_W-1:0] dyn_range_min,
  input wire logic [`IGP_PIX_W-1:0] dyn_range_max
);
  import igp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // expected status from current settings
  // ----------------------------------------
  wire logic [3:0] lay = output_pixel_layout;
  wire logic mos = lay >= 4'h2 && lay <= 4'h9;
  wire logic wide = lay == 4'h1 || (lay >= 4'h6 && lay <= 4'h9);
  wire logic [3:0] base = lay >= 4'h6 ? 4'h6 : 4'h2;
  wire logic [3:0] phase = (lay - base) ^ {2'h0, mirror_rows, mirror_columns};
  wire logic [3:0] rep = mos ? base + phase : lay;
  wire logic [5:0] bpp = lay == `IGP_LAY_RGB8 ? `IGP_BPP_24 :
    lay == `IGP_LAY_MONO12P ? `IGP_BPP_12 : wide ? `IGP_BPP_16 : `IGP_BPP_8;
  wire logic [15:0] dmax = bpp == `IGP_BPP_16 ? 16'hFFFF :
    bpp == `IGP_BPP_12 ? 16'h0FFF : 16'h00FF;
  wire logic known = lay <= 4'hB;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence settled;
    !rst ##1 !rst;
  endsequence

  a_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_pix)) else $error("output dropped in stall");
  a_sensor_cols: assert property (!rst [*3] |-> sensor_column_count == COLS)
    else $error("sensor column count wrong");
  a_sensor_rows: assert property (!rst [*3] |-> sensor_row_count == ROWS)
    else $error("sensor row count wrong");
  a_layout_flip: assert property (settled ##0 known ##1 1'b1 |->
    reported_pixel_layout == $past(rep)) else $error("layout wrong");
  a_filter_none: assert property (settled ##0 !mos ##1 1'b1 |->
    colour_filter == `IGP_FILT_NONE) else $error("filter wrong");
  a_filter_mosaic: assert property (settled ##0 mos ##1 1'b1 |->
    colour_filter == 3'(1 + $past(phase))) else $error("mosaic filter");
  a_pixel_bits: assert property (settled ##0 known ##1 1'b1 |->
    bits_per_output_pixel == $past(bpp)) else $error("pixel bits");
  a_range_max: assert property (settled ##0 known ##1 1'b1 |->
    dyn_range_max == $past(dmax)) else $error("range max wrong");
  a_range_min: assert property (!rst [*3] |-> dyn_range_min == 16'h0000)
    else $error("range min wrong");

  c_stall: cover property (out_valid && !out_ready);
  c_hflip: cover property (mos && mirror_columns);
  c_eof: cover property (out_valid && out_ready && out_pix.eof);
endmodule : igp_top_chk

bind igp_top igp_top_chk #(.COLS(COLS), .ROWS(ROWS)) u_chk (
  .mclk, .rst, .out_valid, .out_ready, .out_pix, .mirror_columns,
  .mirror_rows, .output_pixel_layout, .sensor_column_count,
  .sensor_row_count, .reported_pixel_layout, .colour_filter,
  .bits_per_output_pixel, .dyn_range_min, .dyn_range_max);

// ### test/igp_host_sink.sv
// host side of the processed pixel stream: takes or stalls pixels
// assumes one clock mclk, sync reset rst
module igp_host_sink (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // stall request from the bench
  input wire logic stall_en,
  // pixel stream from the device
  input wire logic out_valid,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  always_ff @(posedge mclk) begin
    if (rst) cnt_r <= 2'h0;
    else cnt_r <= cnt_r + 2'h1;
  end
  // holds off two cycles in four when stalling is asked for
  assign out_ready = !rst && !(stall_en && cnt_r[1]);
endmodule : igp_host_sink

// ### test/igp_top_tb.sv
// bench for igp_top: frame tasks, expected frame model, status checks
// assumes the design files and igp_host_sink are compiled first
`include "igp_regs.svh"

module igp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import igp_pkg::*;
  localparam int COLS = 4;
  localparam int ROWS = 2;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic in_valid, in_ready, out_valid, out_ready, stall_en;
  igp_pix_t in_pix, out_pix;
  logic mirror_columns, mirror_rows, proc_core_enable;
  logic combine_engine_sel, combine_load, skip_layer_sel, skip_load;
  logic [11:0] crop_column_offset, crop_row_offset, crop_width, crop_height;
  logic [11:0] sensor_column_count, sensor_row_count;
  logic [11:0] max_image_width, max_image_height;
  logic [3:0] output_pixel_layout, reported_pixel_layout;
  logic [2:0] column_combine_factor, row_combine_factor, colour_filter;
  logic [2:0] column_skip_factor, row_skip_factor;
  logic [5:0] bits_per_output_pixel;
  logic [15:0] dyn_range_min, dyn_range_max;
  igp_pix_t exp_q[$];
  igp_pix_t got_q[$];
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  // ----------------------------------------
  // design, host and clock
  // ----------------------------------------
  igp_top #(.COLS(COLS), .ROWS(ROWS)) dut (.mclk, .rst, .in_valid,
    .in_pix, .in_ready, .out_valid, .out_pix, .out_ready, .mirror_columns,
    .mirror_rows, .crop_column_offset, .crop_row_offset, .crop_width,
    .crop_height, .output_pixel_layout, .proc_core_enable,
    .combine_engine_sel, .column_combine_factor, .row_combine_factor,
    .combine_load, .skip_layer_sel, .column_skip_factor, .row_skip_factor,
    .skip_load, .sensor_column_count, .sensor_row_count, .max_image_width,
    .max_image_height, .reported_pixel_layout, .colour_filter,
    .bits_per_output_pixel, .dyn_range_min, .dyn_range_max);
  igp_host_sink host (.mclk, .rst, .stall_en, .out_valid, .out_ready);

  always #2.5 mclk = ~mclk;
  // sampled mid-cycle: what stands here is taken at the next rising edge
  always @(negedge mclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) got_q.push_back(out_pix);
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, e, s);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic load(input logic comb, sel, input logic [2:0] fh, fv);
    combine_engine_sel = sel;
    skip_layer_sel = sel;
    column_combine_factor = fh;
    row_combine_factor = fv;
    column_skip_factor = fh;
    row_skip_factor = fv;
    combine_load = comb;
    skip_load = !comb;
    @(posedge mclk);
    #1;
    combine_load = 1'b0;
    skip_load = 1'b0;
    @(posedge mclk);
    #1;
  endtask : load

  task automatic show(input logic [3:0] lay, input logic mh, mv);
    output_pixel_layout = lay;
    mirror_columns = mh;
    mirror_rows = mv;
    repeat (2) @(posedge mclk);
    #1;
  endtask : show

  // sensor pixels carry row plus one in the upper byte, column plus one in the lower
  task automatic run_frame(input int mh, mv, bh, bv, dh, dv, ox, oy, w, h);
    int sr, sc, n;
    logic [15:0] acc;
    igp_pix_t p;
    mirror_columns = mh[0];
    mirror_rows = mv[0];
    crop_column_offset = 12'(ox);
    crop_row_offset = 12'(oy);
    crop_width = 12'(w);
    crop_height = 12'(h);
    exp_q.delete();
    got_q.delete();
    for (int r = 0; r < h; r++) begin
      for (int c = 0; c < w; c++) begin
        acc = 16'h0000;
        for (int i = 0; i < bv; i++) begin
          for (int j = 0; j < bh; j++) begin
            sr = (oy + r) * bv * dv + i;
            sc = (ox + c) * bh * dh + j;
            if (mv != 0) sr = ROWS - 1 - sr;
            if (mh != 0) sc = COLS - 1 - sc;
            acc = acc + 16'h0101 + 16'(sr * 256 + sc);
          end
        end
        p.data = acc;
        p.sof = r == 0 && c == 0;
        p.eol = c == w - 1;
        p.eof = p.eol && r == h - 1;
        exp_q.push_back(p);
      end
    end
    repeat (2) @(posedge mclk);
    #1;
    chk("max width", COLS / (bh * dh), max_image_width);
    chk("max height", ROWS / (bv * dv), max_image_height);
    for (int r = 0; r < ROWS; r++) begin
      for (int c = 0; c < COLS; c++) begin
        in_valid = 1'b1;
        in_pix.data = 16'h0101 + 16'(r * 256 + c);
        in_pix.sof = r == 0 && c == 0;
        // ready is registered: its settled value holds for the next edge
        while (in_ready !== 1'b1) begin
          @(posedge mclk);
          #1;
        end
        @(posedge mclk);
        #1;
      end
    end
    in_valid = 1'b0;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 400) begin
      @(posedge mclk);
      n++;
    end
    repeat (4) @(posedge mclk);
    #1;
    chk("pixel count", exp_q.size(), got_q.size());
    foreach (exp_q[i]) begin
      if (i < got_q.size()) chk("pixel", exp_q[i], got_q[i]);
    end
  endtask : run_frame

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {in_valid, stall_en, proc_core_enable, combine_load, skip_load} = '0;
    {combine_engine_sel, skip_layer_sel, mirror_columns, mirror_rows} = '0;
    {column_combine_factor, row_combine_factor} = '0;
    {column_skip_factor, row_skip_factor} = '0;
    {crop_column_offset, crop_row_offset, crop_width, crop_height} = '0;
    in_pix = '0;
    output_pixel_layout = 4'h0;
    repeat (16) @(posedge mclk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("sensor cols", COLS, sensor_column_count);
    chk("sensor rows", ROWS, sensor_row_count);
    run_frame(0, 0, 1, 1, 1, 1, 0, 0, 4, 2);
    stall_en = 1'b1;
    run_frame(1, 0, 1, 1, 1, 1, 0, 0, 4, 2);
    run_frame(0, 1, 1, 1, 1, 1, 0, 0, 4, 2);
    run_frame(1, 1, 1, 1, 1, 1, 1, 1, 2, 1);
    load(1'b1, 1'b1, 3'h2, 3'h2);
    run_frame(0, 0, 1, 1, 1, 1, 0, 0, 4, 2);
    proc_core_enable = 1'b1;
    run_frame(0, 0, 2, 2, 1, 1, 0, 0, 2, 1);
    load(1'b0, 1'b1, 3'h2, 3'h1);
    run_frame(0, 0, 1, 2, 1, 1, 0, 0, 4, 1);
    load(1'b1, 1'b1, 3'h0, 3'h0);
    load(1'b0, 1'b0, 3'h1, 3'h2);
    run_frame(0, 0, 1, 1, 2, 2, 0, 0, 2, 1);
    run_frame(1, 0, 1, 1, 2, 2, 1, 0, 1, 1);
    for (int l = 0; l < 12; l++) begin
      for (int m = 0; m < 4; m++) show(4'(l), m[0], m[1]);
    end
    show(`IGP_LAY_RG16, 1'b1, 1'b0);
    chk("layout", 4'h7, reported_pixel_layout);
    show(`IGP_LAY_RG16, 1'b0, 1'b1);
    chk("layout", 4'h8, reported_pixel_layout);
    show(`IGP_LAY_MONO8, 1'b0, 1'b0);
    chk("filter", `IGP_FILT_NONE, colour_filter);
    show(`IGP_LAY_MONO12P, 1'b0, 1'b0);
    chk("pixel bits", `IGP_BPP_12, bits_per_output_pixel);
    show(`IGP_LAY_MONO16, 1'b0, 1'b0);
    chk("range min", 16'h0000, dyn_range_min);
    chk("range max", 16'hFFFF, dyn_range_max);
    final_report();
  end
endmodule : igp_top_tb
